// file: rtl/ref_select_pll_divider_cfg.sv
`timescale 1ns/10ps
// Reference select, sync pin and loop divider configuration registers

module ref_select_pll_divider_cfg (
    input wire logic clk,
    input wire logic rst_n,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins
    input wire logic ref_select_pin_lo,
    input wire logic ref_select_pin_hi,
    input wire logic switchEvent,
    input wire logic syncPinIn,
    output logic syncPinOut,
    output logic syncPinOe,
    input wire logic [3:0] statusSources,
    output logic syncOutputs,
    // Settings to the analog loops
    output logic [1:0] activeRef,
    output logic [1:0] ref_predivider,
    output logic [13:0] loop1_ref_counter,
    output logic [13:0] loop1_fb_counter,
    output logic [27:0] loop1_ref_total,
    output logic [11:0] loop2_ref_counter,
    output logic [17:0] loop2_fb_counter,
    output logic [3:0] loop2_prescaler,
    output logic [3:0] vcoDivider,
    output logic [25:0] loop2_fb_total,
    output logic loop2_ref_doubler_en,
    output refsel_pkg::pump_s loop1Pump,
    output refsel_pkg::pump_s loop2Pump
);

    ////////////////////////////////////////////////////////////////////////
    // Bus slave

    logic awHeld;            // Write address taken, awaiting data
    logic wHeld;             // Write data taken, awaiting address
    logic [7:0] awAddr;      // Captured write address
    logic [31:0] wData;      // Captured write data
    logic [3:0] wStrb;       // Captured strobes
    logic doWrite;           // One-cycle commit pulse
    logic [7:0] wrSel;       // Which word commits

    // Decode a word offset into its register index; 8 is the status word, 15 means unmapped
    function automatic logic [3:0] decode(input logic [7:0] a);
        unique case (a)
            refsel_pkg::OFF_REFSEL: decode = 4'h0;
            refsel_pkg::OFF_PREDIV: decode = 4'h1;
            refsel_pkg::OFF_L1REF: decode = 4'h2;
            refsel_pkg::OFF_L1FB: decode = 4'h3;
            refsel_pkg::OFF_L2REF: decode = 4'h4;
            refsel_pkg::OFF_L2FB: decode = 4'h5;
            refsel_pkg::OFF_L2DIV: decode = 4'h6;
            refsel_pkg::OFF_PUMP: decode = 4'h7;
            refsel_pkg::OFF_STATUS: decode = 4'h8;
            default: decode = 4'hf;
        endcase
    endfunction

    // Address and data channels taken in either order
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= 8'h00;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end else if (doWrite) begin
                awHeld <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end else if (doWrite) begin
                wHeld <= 1'b0;
            end
        end
    end

    assign doWrite = awHeld && wHeld && !s_axi_bvalid;

    // Ready only while the channel slot is empty and no answer pending
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready)
                             && !s_axi_bvalid;
            s_axi_wready <= !wHeld && !(s_axi_wvalid && s_axi_wready)
                            && !s_axi_bvalid;
        end
    end

    // Write response, SLVERR for unmapped or read-only words
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (decode(awAddr) < 4'h8) ? 2'h0 : 2'h2;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Per-word write enables
    always_comb begin
        wrSel = 8'h00;
        if (doWrite && decode(awAddr) < 4'h8) begin
            wrSel[3'(decode(awAddr))] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register words

    logic [31:0] regVal [8];   // Stored words
    logic [7:0] clampHit;      // Write clamped this cycle

    // Reset, minimum and maximum for each word
    localparam logic [31:0] RSTS [8] = '{refsel_pkg::RST_REFSEL,
        refsel_pkg::RST_PREDIV, refsel_pkg::RST_ONE, refsel_pkg::RST_ONE,
        refsel_pkg::RST_ONE, refsel_pkg::RST_ONE, refsel_pkg::RST_L2DIV,
        refsel_pkg::RST_PUMP};
    localparam logic [31:0] MINS [8] = '{32'h0, 32'h0, 32'h1, 32'h1,
        32'h1, 32'h1, 32'h0, 32'h0};
    localparam logic [31:0] MAXS [8] = '{32'h3ff, 32'hfff,
        {18'h0, refsel_pkg::L1_MAX}, {18'h0, refsel_pkg::L1_MAX},
        {20'h0, refsel_pkg::L2R_MAX}, {14'h0, refsel_pkg::L2N_MAX},
        32'h1ff, 32'hff};

    // counter words clamp to their ranges
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : gWord
            refsel_reg_word #(
                .RESET(RSTS[g]),
                .MINV(MINS[g]),
                .MAXV(MAXS[g])
            ) uWord (
                .clk(clk),
                .rst_n(rst_n),
                .wrEn(wrSel[g]),
                .wrData(wData),
                .wrStrb(wStrb),
                .value(regVal[g]),
                .clampHit(clampHit[g])
            );
        end
    endgenerate

    // Clamp a 4-bit divide field into 2..8
    function automatic logic [3:0] clampDiv(input logic [3:0] v);
        if (v < refsel_pkg::DIV_MIN) begin
            clampDiv = refsel_pkg::DIV_MIN;
        end else if (v > refsel_pkg::DIV_MAX) begin
            clampDiv = refsel_pkg::DIV_MAX;
        end else begin
            clampDiv = v;
        end
    endfunction

    logic [2:0] selMode;   // Reference selection mode
    logic [2:0] syncMux;   // Sync pin source selector
    assign selMode = regVal[0][refsel_pkg::MODE_LSB +: 3];
    assign syncMux = regVal[0][refsel_pkg::SMUX_LSB +: 3];

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [3:0] pinsSync;   // hi, lo, switch event, sync pin
    refsel_sync2 #(.W(4)) uPinSync (
        .clk(clk),
        .rst_n(rst_n),
        .din({ref_select_pin_hi, ref_select_pin_lo, switchEvent, syncPinIn}),
        .dout(pinsSync)
    );

    logic switchPrev;  // Edge detect on synchronised switch event
    logic syncPrev;    // Edge detect on synchronised sync level
    logic reservedHit; // Event-mode sample found both pins low

    ////////////////////////////////////////////////////////////////////////
    // Reference selection

    // Choose active reference by mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            activeRef <= refsel_pkg::REF_IN0;
            switchPrev <= 1'b0;
            reservedHit <= 1'b0;
        end else begin
            switchPrev <= pinsSync[1];
            if (selMode == refsel_pkg::MODE_PIN) begin
                // direct pin select, 11 means holdover
                activeRef <= pinsSync[3:2];
            end else if (selMode == refsel_pkg::MODE_EVENT
                         && pinsSync[1] && !switchPrev) begin
                // sample only on switch event, 00 reserved
                if (pinsSync[2]) begin
                    activeRef <= refsel_pkg::REF_IN0;
                end else if (pinsSync[3]) begin
                    activeRef <= refsel_pkg::REF_IN1;
                end else begin
                    reservedHit <= 1'b1;
                end
            end
            // Software clear loses to a new reserved sample
            if (wrSel[0] && wData[refsel_pkg::SYNC_CLR_BIT]) begin
                reservedHit <= (selMode == refsel_pkg::MODE_EVENT
                    && pinsSync[1] && !switchPrev && pinsSync[3:2] == 2'b00);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sync pin

    logic [3:0] syncCnt;  // Sync pulse stretch counter
    logic syncGo;         // Sync trigger this cycle

    // Input sync edge or software request, only while pin is an input
    assign syncGo = (syncMux < refsel_pkg::SMUX_OUT_LO
                     || syncMux > refsel_pkg::SMUX_OUT_HI)
                    && ((pinsSync[0] && !syncPrev)
                        || (wrSel[0] && wData[refsel_pkg::SYNCGO_BIT]));

    // stretched sync pulse aligns the chosen outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncPrev <= 1'b0;
            syncCnt <= 4'h0;
            syncOutputs <= 1'b0;
        end else begin
            syncPrev <= pinsSync[0];
            if (syncGo) begin
                syncCnt <= refsel_pkg::SYNC_PULSE_CYC;
                syncOutputs <= 1'b1;
            end else if (syncCnt != 4'h0) begin
                syncCnt <= syncCnt - 4'h1;
                syncOutputs <= (syncCnt != 4'h1);
            end
        end
    end

    // selector 3..6 turns the pin into a status output
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncPinOe <= 1'b0;
            syncPinOut <= 1'b0;
        end else begin
            syncPinOe <= syncMux >= refsel_pkg::SMUX_OUT_LO
                         && syncMux <= refsel_pkg::SMUX_OUT_HI;
            syncPinOut <= (syncMux >= refsel_pkg::SMUX_OUT_LO
                           && syncMux <= refsel_pkg::SMUX_OUT_HI)
                ? statusSources[2'(syncMux - refsel_pkg::SMUX_OUT_LO)]
                : 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Loop settings

    logic [3:0] prediv;  // Predivider of the active input

    always_comb begin
        unique case (activeRef)
            refsel_pkg::REF_IN0: prediv = regVal[1][3:0];
            refsel_pkg::REF_IN1: prediv = regVal[1][7:4];
            default: prediv = regVal[1][11:8];
        endcase
    end

    // Settings and derived division totals
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_predivider <= 2'h1;
            loop1_ref_counter <= 14'h1;
            loop1_fb_counter <= 14'h1;
            loop1_ref_total <= 28'h1;
            loop2_ref_counter <= 12'h1;
            loop2_fb_counter <= 18'h1;
            loop2_prescaler <= refsel_pkg::DIV_MIN;
            vcoDivider <= refsel_pkg::DIV_MIN;
            loop2_fb_total <= 26'h4;
            loop2_ref_doubler_en <= 1'b0;
        end else begin
            ref_predivider <= prediv[1:0];
            // loop 1 counters from clamped words
            loop1_ref_counter <= regVal[2][13:0];
            loop1_fb_counter <= regVal[3][13:0];
            // detector divides by counter times predivider
            loop1_ref_total <= regVal[2][13:0] * {12'h0, prediv[1:0]};
            loop2_ref_counter <= regVal[4][11:0];
            loop2_fb_counter <= regVal[5][17:0];
            loop2_prescaler <= clampDiv(regVal[6][refsel_pkg::L2P_LSB +: 4]);
            vcoDivider <= clampDiv(regVal[6][refsel_pkg::VDIV_LSB +: 4]);
            // total feedback is VCO div * prescaler * counter
            loop2_fb_total <= 26'(clampDiv(regVal[6][7:4])
                * clampDiv(regVal[6][3:0]) * regVal[5][17:0]);
            // doubler bit, 1 doubles the reference
            loop2_ref_doubler_en <= regVal[6][refsel_pkg::DBL_BIT];
        end
    end

    // gain codes, polarity and tristate for both loops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            loop1Pump <= '0;
            loop2Pump <= '0;
        end else begin
            loop1Pump <= {regVal[7][refsel_pkg::G1_LSB +: 2],
                regVal[7][refsel_pkg::POL1_BIT],
                regVal[7][refsel_pkg::TRI1_BIT]};
            loop2Pump <= {regVal[7][refsel_pkg::G2_LSB +: 2],
                regVal[7][refsel_pkg::POL2_BIT],
                regVal[7][refsel_pkg::TRI2_BIT]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel

    logic [31:0] statusWord;  // Block state seen by software
    assign statusWord = {22'h0, |clampHit, reservedHit, syncOutputs,
                         syncPinOe, 2'h0, activeRef, 2'h0};

    // One read at a time, answer two cycles after address
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready
                             && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= (decode(s_axi_araddr) == 4'hf) ? 2'h2 : 2'h0;
                if (decode(s_axi_araddr) == 4'h8) begin
                    s_axi_rdata <= statusWord;
                end else if (decode(s_axi_araddr) < 4'h8) begin
                    s_axi_rdata <= regVal[3'(decode(s_axi_araddr))];
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                end
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// file: pkg/refsel_pkg.sv
// Package: register map, field layouts, limits and shared types
package refsel_pkg;

    // Register byte offsets (AXI4-Lite, one aligned word each)
    localparam logic [7:0] OFF_REFSEL = 8'h00;   // Selection mode, sync mux
    localparam logic [7:0] OFF_PREDIV = 8'h04;   // Predividers 0..2
    localparam logic [7:0] OFF_L1REF = 8'h08;    // Loop 1 reference counter
    localparam logic [7:0] OFF_L1FB = 8'h0c;     // Loop 1 feedback counter
    localparam logic [7:0] OFF_L2REF = 8'h10;    // Loop 2 reference counter
    localparam logic [7:0] OFF_L2FB = 8'h14;     // Loop 2 feedback counter
    localparam logic [7:0] OFF_L2DIV = 8'h18;    // Prescaler, VCO div, doubler
    localparam logic [7:0] OFF_PUMP = 8'h1c;     // Pump gain, polarity, tri
    localparam logic [7:0] OFF_STATUS = 8'h20;   // Active ref, errors, sync

    // Field positions
    localparam int MODE_LSB = 0;      // 3-bit selection mode
    localparam int SMUX_LSB = 4;      // 3-bit sync pin source
    localparam int SYNCGO_BIT = 8;    // Software sync request
    localparam int SYNC_CLR_BIT = 9;  // Write 1 clears the reserved flag
    localparam int L2P_LSB = 0;       // 4-bit prescaler
    localparam int VDIV_LSB = 4;      // 4-bit VCO divider
    localparam int DBL_BIT = 8;       // Reference doubler enable
    localparam int G1_LSB = 0;        // Loop 1 gain code
    localparam int POL1_BIT = 2;
    localparam int TRI1_BIT = 3;
    localparam int G2_LSB = 4;        // Loop 2 gain code
    localparam int POL2_BIT = 6;
    localparam int TRI2_BIT = 7;

    // Modes and codes
    localparam logic [2:0] MODE_PIN = 3'h3;     // Direct pin select
    localparam logic [2:0] MODE_EVENT = 3'h6;   // Pins sampled on switch
    localparam logic [2:0] SMUX_OUT_LO = 3'h3;  // Output range start
    localparam logic [2:0] SMUX_OUT_HI = 3'h6;  // Output range end

    // Divider limits
    localparam logic [13:0] L1_MAX = 14'h3fff;   // 16383
    localparam logic [11:0] L2R_MAX = 12'hfff;   // 4095
    localparam logic [17:0] L2N_MAX = 18'h3ffff; // 262143
    localparam logic [3:0] DIV_MIN = 4'h2;
    localparam logic [3:0] DIV_MAX = 4'h8;

    // Reset values
    localparam logic [31:0] RST_REFSEL = 32'h0000_0000;
    localparam logic [31:0] RST_PREDIV = 32'h0000_0111;
    localparam logic [31:0] RST_ONE = 32'h0000_0001;
    localparam logic [31:0] RST_L2DIV = 32'h0000_0022;
    localparam logic [31:0] RST_PUMP = 32'h0000_0000;

    // Sync pulse stretch length in clocks
    localparam logic [3:0] SYNC_PULSE_CYC = 4'h8;

    // Reference choice
    typedef enum logic [1:0] {REF_IN0, REF_IN1, REF_IN2, REF_HOLD} ref_e;

    // Pump setting bundle for one loop
    typedef struct packed {
        logic [1:0] gain;
        logic polarity;
        logic tristate;
    } pump_s;

endpackage

// file: rtl/refsel_reg_word.sv
`timescale 1ns/10ps
// One software register word with clamped write of a divide value
module refsel_reg_word #(
    parameter logic [31:0] RESET = 32'h0000_0000,
    parameter logic [31:0] MINV = 32'h0000_0000,
    parameter logic [31:0] MAXV = 32'hffff_ffff
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wrEn,
    input wire logic [31:0] wrData,
    input wire logic [3:0] wrStrb,
    output logic [31:0] value,
    output logic clampHit
);
    logic [31:0] merged;  // Old word with strobed bytes replaced

    // Byte merge by strobe
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            merged[i*8 +: 8] = wrStrb[i] ? wrData[i*8 +: 8] : value[i*8 +: 8];
        end
    end

    // Store, holding the value within its legal range
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            value <= RESET;
            clampHit <= 1'b0;
        end else if (wrEn) begin
            // Out-of-range writes clamp rather than fault the loop
            if (merged < MINV) begin
                value <= MINV;
                clampHit <= 1'b1;
            end else if (merged > MAXV) begin
                value <= MAXV;
                clampHit <= 1'b1;
            end else begin
                value <= merged;
                clampHit <= 1'b0;
            end
        end else begin
            clampHit <= 1'b0;
        end
    end
endmodule

// file: rtl/refsel_sync2.sv
`timescale 1ns/10ps
// Two-flop synchroniser for pin levels
module refsel_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] stage1;  // Read only by the second stage

    // Metastability filter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            dout <= '0;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule

// file: sim/refsel_far_model.sv
// Far-side model: reference select pins, switch event and sync pin
`timescale 1ns/10ps
module refsel_far_model (
    input wire logic clk,
    input wire logic [1:0] pinReq,
    input wire logic evtReq,
    input wire logic syncReq,
    input wire logic syncPinOe,
    input wire logic syncPinOut,
    output logic ref_select_pin_lo,
    output logic ref_select_pin_hi,
    output logic switchEvent,
    output logic syncPinIn
);
    logic syncDrv; // Level the board puts on the sync pin
    // Known levels at time zero, before the first edge
    initial begin
        {ref_select_pin_hi, ref_select_pin_lo, switchEvent, syncDrv} = '0;
    end
    // Pins move just after an edge, like a board-level driver
    always @(posedge clk) begin
        {ref_select_pin_hi, ref_select_pin_lo} <= pinReq;
        switchEvent <= evtReq;
        syncDrv <= syncReq;
    end
    // The far side lets go of the pin while the device drives it
    assign syncPinIn = syncPinOe ? syncPinOut : syncDrv;
endmodule

// file: sim/refsel_cfg_checker.sv
// Checker of bus holding, divide ranges and sync pulse at the ports
`timescale 1ns/10ps
module refsel_cfg_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic syncPinIn,
    input wire logic syncPinOe,
    input wire logic syncOutputs,
    input wire logic [13:0] loop1_ref_counter,
    input wire logic [13:0] loop1_fb_counter,
    input wire logic [11:0] loop2_ref_counter,
    input wire logic [17:0] loop2_fb_counter,
    input wire logic [3:0] loop2_prescaler,
    input wire logic [3:0] vcoDivider,
    input wire logic [25:0] loop2_fb_total
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid) else $error("write answer dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
    l1_counters_a: assert property (
        loop1_ref_counter != '0 && loop1_fb_counter != '0)
        else $error("loop 1 counter zero");
    l2_counters_a: assert property (
        loop2_ref_counter != '0 && loop2_fb_counter != '0)
        else $error("loop 2 counter zero");
    div_range_a: assert property (
        loop2_prescaler inside {[2:8]} && vcoDivider inside {[2:8]})
        else $error("divider out of range");
    fb_total_a: assert property (
        loop2_fb_total == vcoDivider * loop2_prescaler * loop2_fb_counter)
        else $error("feedback total wrong");
    // A sync pulse stands for its whole stretch
    sync_pulse_a: assert property (
        $rose(syncOutputs) |-> syncOutputs [*8])
        else $error("sync pulse short");
    sync_start_a: assert property (
        !syncPinOe && $rose(syncPinIn) |-> ##[1:6] syncOutputs)
        else $error("sync not started");
    // Main scenarios reached
    cover property (s_axi_bvalid && s_axi_bready);
    cover property ($rose(syncOutputs));
    cover property (syncPinOe);
endmodule
bind ref_select_pll_divider_cfg refsel_cfg_checker chk_u (.*);

// file: sim/ref_select_pll_divider_cfg_bench.sv
// Bench: ranges, pump codes, reference select and sync pin checks
`timescale 1ns/10ps
module ref_select_pll_divider_cfg_bench;
    logic clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, syncPinOut;
    logic syncPinOe, syncOutputs, ref_select_pin_lo, ref_select_pin_hi;
    logic switchEvent, syncPinIn, loop2_ref_doubler_en, evtReq, syncReq;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, ex[4], v, p, q;
    logic [3:0] s_axi_wstrb, statusSources, loop2_prescaler, vcoDivider;
    logic [1:0] s_axi_bresp, s_axi_rresp, activeRef, ref_predivider;
    logic [1:0] pinReq, r;
    logic [13:0] loop1_ref_counter, loop1_fb_counter;
    logic [11:0] loop2_ref_counter;
    logic [17:0] loop2_fb_counter;
    logic [27:0] loop1_ref_total;
    logic [25:0] loop2_fb_total;
    refsel_pkg::pump_s loop1Pump, loop2Pump;
    logic [31:0] mx[4] = '{32'h3fff, 32'h3fff, 32'hfff, 32'h3ffff};
    int errors = 0, testsRun = 0, seed = 89, i, k, n;
    ref_select_pll_divider_cfg dut_u (.*);
    refsel_far_model far_u (.*);
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] g, input logic [31:0] e);
        testsRun++;
        if (g !== e) begin
            errors++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    // A spent bound counts as a mismatch and ends the run
    task lim;
        if (n >= 40) begin
            errors++;
            finish_test;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (n = 0; n < 40 && !s_axi_bvalid; n++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        lim;
        @(posedge clk);
    endtask
    task rd(input logic [7:0] a);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        for (n = 0; n < 40 && !s_axi_rvalid; n++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end
        {v, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'h0;
        lim;
        @(posedge clk);
    endtask
    // Switch event held long enough for the input synchroniser
    task pulse(input logic [1:0] pins);
        pinReq <= pins;
        repeat (4) @(posedge clk);
        evtReq <= 1'h1;
        repeat (4) @(posedge clk);
        evtReq <= 1'h0;
        repeat (6) @(posedge clk);
    endtask
    task waitRef(input logic [1:0] e);
        for (n = 0; n < 12 && activeRef !== e; n++) @(posedge clk);
        chk(activeRef, e);
    endtask
    function logic [31:0] lim2(input logic [31:0] x, lo, hi);
        return x < lo ? lo : x > hi ? hi : x;
    endfunction
    function logic [31:0] cnt(input int j);
        return j == 0 ? 32'(loop1_ref_counter) : j == 1 ?
            32'(loop1_fb_counter) : j == 2 ? 32'(loop2_ref_counter) :
            32'(loop2_fb_counter);
    endfunction
    task finish_test;
        $display("compares %0d mismatches %0d", testsRun, errors);
        if (errors == 0 && testsRun > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, s_axi_wstrb, statusSources} = '0;
        {pinReq, evtReq, syncReq} = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        chk({loop1_ref_counter, loop2_fb_counter}, 32'h4_0001);
        chk({loop2_prescaler, vcoDivider}, 32'h22);
        // Zero, one past the top, then random values
        for (i = 0; i < 16; i++) begin
            k = i % 4;
            v = i < 4 ? '0 : i < 8 ? mx[k] + 1 : $random(seed) & mx[k] * 2;
            wr(8'h08 + 8'(k * 4), v);
            ex[k] = lim2(v, 32'h1, mx[k]);
            chk(cnt(k), ex[k]);
        end
        $display("test ranges done");
        for (i = 0; i < 6; i++) begin
            v = i == 0 ? 32'h190 : $random(seed) & 32'h1ff;
            wr(8'h18, v);
            p = lim2(v[3:0], 32'h2, 32'h8);
            q = lim2(v[7:4], 32'h2, 32'h8);
            chk({loop2_ref_doubler_en, vcoDivider, loop2_prescaler},
                {v[8], q[3:0], p[3:0]});
            chk(loop2_fb_total, p * q * ex[3]);
        end
        for (i = 0; i < 4; i++) begin
            v = ($random(seed) & 32'hcc) | 32'(i) | 32'(i << 4);
            wr(8'h1c, v);
            chk({loop2Pump, loop1Pump}, {v[5:4], v[6], v[7], v[1:0],
                v[2], v[3]});
        end
        $display("test dividers done");
        wr(8'h00, 32'h3);
        for (i = 0; i < 4; i++) begin
            pinReq <= 2'(i);
            waitRef(2'(i));
        end
        wr(8'h00, 32'h6);
        pulse(2'h1);
        waitRef(2'h0);
        pinReq <= 2'h2;
        repeat (12) @(posedge clk);
        chk(activeRef, 2'h0);
        pulse(2'h2);
        waitRef(2'h1);
        pulse(2'h0);
        rd(8'h20);
        chk(v[8], 1'h1);
        wr(8'h04, 32'h321);
        chk({ref_predivider, loop1_ref_total}, {2'h2, 28'(ex[0] * 2)});
        $display("test select done");
        // Unmapped read and a status write are refused
        rd(8'h24);
        chk(r, 2'h2);
        wr(8'h20, '0);
        chk(r, 2'h2);
        syncReq <= 1'h1;
        k = 0;
        for (i = 0; i < 24; i++) begin
            @(posedge clk);
            k += syncOutputs;
        end
        syncReq <= 1'h0;
        chk(k, 8);
        for (i = 2; i < 7; i++) begin
            wr(8'h00, 32'(i << 4));
            statusSources <= 4'($random(seed));
            repeat (6) @(posedge clk);
            chk({syncPinOe, syncPinOe & syncPinOut},
                {i > 2, i > 2 && statusSources[i - 3]});
        end
        $display("test sync done");
        finish_test;
    end
endmodule
